/* File: hw/smpwm_clkdiv.sv */
// Purpose: Clock source select and power-of-two prescaler for the PWM tick
// Assumes: Source requests are one-cycle pulses in the hclk domain
// Notes: Produces a one-cycle enable pulse, never a derived clock
module smpwm_clkdiv
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [1:0] source_sel,
    input wire logic [1:0] prescale_sel,
    input wire logic sys_tick,
    input wire logic pll_tick,
    input wire logic pin_tick,
    output logic pwm_tick
);
    import smpwm_pkg::*;

    logic src_tick;
    logic [2:0] div_count;
    logic [2:0] div_limit;

    // Source mux; reserved code gives no tick
    always_comb
    begin
        case (source_sel)
            CSRC_SYSTEM: src_tick = sys_tick;
            CSRC_PLL: src_tick = pll_tick;
            CSRC_PIN: src_tick = pin_tick;
            default: src_tick = 1'b0;
        endcase
    end

    // Divide by 1, 2, 4 or 8
    assign div_limit = 3'((4'h1 << prescale_sel) - 4'h1);

    // Prescale counter, held clear while the unit is stopped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_count <= 3'h0;
        else if (!run)
            div_count <= 3'h0;
        else if (src_tick)
            div_count <= (div_count >= div_limit) ? 3'h0 : div_count + 3'h1;
    end

    assign pwm_tick = run && src_tick && (div_count >= div_limit);

    a_prescale_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
        (run && prescale_sel == 2'b00 && src_tick) |-> pwm_tick)
        else $error("undivided source tick did not pass");
endmodule : smpwm_clkdiv

/* File: hw/smpwm_regs.sv */
// Purpose: Control and configuration registers of one switch-mode PWM unit
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes: Instance selects unit one or two; the pin timing logic lies elsewhere
// What this block does
// - Bit 5 enables falling dead band, bit 4 rising dead band.
// - Mode field decodes single, skip, skip complementary, three-phase; 1101-1111 reserved.
// - Modulation polarity one makes the source active low.
// - Source 0000 with modulation enabled uses the software level bit.
// - Software level ignored otherwise; modulation off keeps the unit active.
// - Unit one sync field: 10 follows unit two, 00 none, 01 reserved.
// - Unit two sync field: 01 follows unit one, 00 none, 10 reserved.
// - Clock source: 00 system, 01 PLL, 10 external pin, 11 reserved.
// - Output enable bits 5-0 route PWM to pins, else port logic owns them.
// - Unit two lacks output enable bits for outputs C to F.
// - All bits clear on any reset; unimplemented bits read zero.
// - Load request copies buffers at next period event, then self-clears.
// - While disabled, buffered register writes go straight to the active copy.
// - A sync slave takes the master period event as its own period event.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
module smpwm_regs
#(
    parameter int UNIT_INDEX = 1
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pll_tick,
    input wire logic ext_clock_pin,
    input wire logic ext_feedback_input,
    input wire logic [2:0] comparator_out,
    input wire logic capture_compare_unit_one,
    input wire logic capture_compare_unit_two,
    input wire logic master_period_event,
    output logic period_event,
    output logic unit_active,
    output logic modulation_gate,
    output logic fall_deadband_enable,
    output logic rise_deadband_enable,
    output logic mode_single,
    output logic mode_skip,
    output logic mode_skip_comp,
    output logic mode_three_phase,
    output logic [5:0] output_pin_enable,
    output logic [31:0] active_data
);
    import smpwm_pkg::*;

    // Only two units exist; any other index is refused at elaboration
    if (UNIT_INDEX != 1 && UNIT_INDEX != 2)
    begin : g_bad_unit
        $error("UNIT_INDEX must be 1 or 2");
    end

    localparam logic [7:0] OE_MASK = (UNIT_INDEX == 1) ? MASK_OE_FULL : MASK_OE_PAIR;

    logic [7:0] pwm_main_control;
    logic [7:0] pwm_modulation_control;
    logic [7:0] unit_period_sync;
    logic [7:0] pwm_clock_select;
    logic [7:0] pwm_output_enable;
    logic [31:0] buffer_data;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [2:0] pin_sync;
    logic [1:0] fb_sync;
    logic pin_tick;
    logic pwm_tick;
    logic [7:0] period_count;
    logic local_event;
    logic sync_follow;
    logic pwm_unit_enable;
    logic buffer_load_request;
    logic [3:0] modulation_source_sel;
    logic mod_source;
    logic [31:0] write_value;

    assign pwm_unit_enable = pwm_main_control[POS_UNIT_ENABLE];
    assign buffer_load_request = pwm_main_control[POS_LOAD_REQUEST];
    assign modulation_source_sel = pwm_modulation_control[3:0];
    assign write_value = hwdata;

    // Address phase capture; writes complete in the following data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans == HTRANS_NONSEQ && hwrite && hsize == HSIZE_WORD;
            wr_addr <= haddr[11:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic logic hit(input logic [11:0] ofs);
        hit = wr_pend && wr_addr == ofs;
    endfunction : hit

    // Register writes; unimplemented bits never store
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_main_control <= RST_REG8;
            pwm_modulation_control <= RST_REG8;
            unit_period_sync <= RST_REG8;
            pwm_clock_select <= RST_REG8;
            pwm_output_enable <= RST_REG8;
            buffer_data <= RST_WORD;
        end
        else
        begin
            if (hit(OFS_MAIN_CONTROL))
                pwm_main_control <= write_value[7:0] & MASK_MAIN;
            else if (local_event && pwm_unit_enable)
                pwm_main_control[POS_LOAD_REQUEST] <= 1'b0;
            if (hit(OFS_MODULATION))
                pwm_modulation_control <= write_value[7:0] & MASK_MOD;
            if (hit(UNIT_INDEX == 1 ? OFS_UNIT1_SYNC : OFS_UNIT2_SYNC))
                unit_period_sync <= write_value[7:0] & MASK_SYNC;
            if (hit(OFS_CLOCK_SELECT))
                pwm_clock_select <= write_value[7:0] & MASK_CLOCK;
            if (hit(OFS_OUTPUT_ENABLE))
                pwm_output_enable <= write_value[7:0] & OE_MASK;
            if (hit(OFS_BUFFER_DATA))
                buffer_data <= write_value;
        end
    end

    // Active copy: direct while disabled, on period event when load requested
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            active_data <= RST_WORD;
        else if (!pwm_unit_enable && hit(OFS_BUFFER_DATA))
            active_data <= write_value;
        else if (pwm_unit_enable && buffer_load_request && local_event)
            active_data <= buffer_data;
    end

    // Read mux, address registered in the address phase, then decoded combinationally
    logic [11:0] rd_addr;
    logic [31:0] next_hrdata;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_addr <= 12'h000;
        else if (hready)
            rd_addr <= haddr[11:0];
    end

    always_comb
    begin
        if (rd_addr == OFS_MAIN_CONTROL)
            next_hrdata = {24'h0, pwm_main_control};
        else if (rd_addr == OFS_MODULATION)
            next_hrdata = {24'h0, pwm_modulation_control};
        else if (rd_addr == (UNIT_INDEX == 1 ? OFS_UNIT1_SYNC : OFS_UNIT2_SYNC))
            next_hrdata = {24'h0, unit_period_sync};
        else if (rd_addr == OFS_CLOCK_SELECT)
            next_hrdata = {24'h0, pwm_clock_select};
        else if (rd_addr == OFS_OUTPUT_ENABLE)
            next_hrdata = {24'h0, pwm_output_enable};
        else if (rd_addr == OFS_BUFFER_DATA)
            next_hrdata = buffer_data;
        else if (rd_addr == OFS_ACTIVE_DATA)
            next_hrdata = active_data;
        else
            next_hrdata = 32'h0000_0000; // Unmapped reads zero
    end
    assign hrdata = next_hrdata;

    // External clock pin and feedback pin synchronisers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_sync <= 3'h0;
            fb_sync <= 2'h0;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], ext_clock_pin};
            fb_sync <= {fb_sync[0], ext_feedback_input};
        end
    end
    assign pin_tick = pin_sync[1] && !pin_sync[2];

    // Clock source and prescaler
    smpwm_clkdiv u_clkdiv
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(pwm_unit_enable),
        .source_sel(pwm_clock_select[1:0]),
        .prescale_sel(pwm_clock_select[5:4]),
        .sys_tick(1'b1),
        .pll_tick(pll_tick),
        .pin_tick(pin_tick),
        .pwm_tick(pwm_tick)
    );

    // Sync follow decode per unit; reserved codes act as unsynchronised
    assign sync_follow = (UNIT_INDEX == 1) ? unit_period_sync[1:0] == SYNC_U1_FOLLOW
                                           : unit_period_sync[1:0] == SYNC_U2_FOLLOW;

    // Period counter; master event realigns a slave
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            period_count <= 8'h00;
        else if (!pwm_unit_enable)
            period_count <= 8'h00;
        else if (sync_follow && master_period_event)
            period_count <= 8'h00;
        else if (pwm_tick)
            period_count <= (period_count == PERIOD_TICKS) ? 8'h00 : period_count + 8'h01;
    end

    assign local_event = pwm_unit_enable && ((pwm_tick && period_count == PERIOD_TICKS)
                         || (sync_follow && master_period_event));
    assign period_event = local_event;

    // Modulation source select
    always_comb
    begin
        if (modulation_source_sel == MSRC_SOFT)
            mod_source = pwm_modulation_control[POS_MOD_SOFT];
        else if (modulation_source_sel <= MSRC_CMP_LAST)
            mod_source = comparator_out[2'(modulation_source_sel - 4'h1)];
        else if (modulation_source_sel == MSRC_CAPCMP_ONE)
            mod_source = capture_compare_unit_one;
        else if (modulation_source_sel == MSRC_CAPCMP_TWO)
            mod_source = capture_compare_unit_two;
        else if (modulation_source_sel == MSRC_FEEDBACK)
            mod_source = fb_sync[1];
        else
            mod_source = 1'b0;
    end

    // Gate: polarity inverts source; disabled modulation keeps it open
    assign modulation_gate = !pwm_modulation_control[POS_MOD_ENABLE]
        || (mod_source ^ pwm_modulation_control[POS_MOD_POLARITY]);

    assign unit_active = pwm_unit_enable && modulation_gate;
    assign fall_deadband_enable = pwm_main_control[POS_FALL_DB];
    assign rise_deadband_enable = pwm_main_control[POS_RISE_DB];
    assign mode_single = pwm_main_control[3:0] == MODE_SINGLE;
    assign mode_skip = pwm_main_control[3:0] == MODE_SKIP;
    assign mode_skip_comp = pwm_main_control[3:0] == MODE_SKIP_COMP;
    assign mode_three_phase = pwm_main_control[3:0] == MODE_THREE_PHASE;
    assign output_pin_enable = pwm_output_enable[5:0];

    a_disabled_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwm_unit_enable |-> !unit_active && !period_event)
        else $error("unit active while disabled");
    a_load_self_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_unit_enable && buffer_load_request && local_event && !hit(OFS_MAIN_CONTROL))
        |=> !buffer_load_request && active_data == $past(buffer_data))
        else $error("load request not serviced");
    a_direct_load: assert property (@(posedge hclk) disable iff (!hresetn)
        (!pwm_unit_enable && hit(OFS_BUFFER_DATA)) |=> active_data == $past(hwdata))
        else $error("disabled write missed active copy");
    a_slave_realign: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_unit_enable && sync_follow && master_period_event) |-> period_event
        ##1 period_count == 8'h00)
        else $error("slave did not realign");
    a_mod_off_open: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwm_modulation_control[POS_MOD_ENABLE] |-> modulation_gate)
        else $error("gate closed with modulation off");
    a_soft_level: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_modulation_control[POS_MOD_ENABLE] && modulation_source_sel == MSRC_SOFT)
        |-> modulation_gate == (pwm_modulation_control[POS_MOD_SOFT]
        != pwm_modulation_control[POS_MOD_POLARITY]))
        else $error("software level misapplied");
    a_oe_unit_two: assert property (@(posedge hclk) disable iff (!hresetn)
        UNIT_INDEX == 2 |-> output_pin_enable[5:2] == 4'h0)
        else $error("unit two drives C to F");
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        pwm_modulation_control[4] == 1'b0 && pwm_clock_select[7:6] == 2'b00
        && unit_period_sync[7:2] == 6'h00)
        else $error("unimplemented bit set");
endmodule : smpwm_regs

/* File: include/smpwm_pkg.sv */
// Purpose: Shared constants for the switch-mode PWM control register block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Byte offsets are local choices; fields follow the register layouts
package smpwm_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_MAIN_CONTROL = 12'h000;
    localparam logic [11:0] OFS_MODULATION = 12'h004;
    localparam logic [11:0] OFS_UNIT1_SYNC = 12'h008;
    localparam logic [11:0] OFS_UNIT2_SYNC = 12'h00c;
    localparam logic [11:0] OFS_CLOCK_SELECT = 12'h010;
    localparam logic [11:0] OFS_OUTPUT_ENABLE = 12'h014;
    localparam logic [11:0] OFS_BUFFER_DATA = 12'h018;
    localparam logic [11:0] OFS_ACTIVE_DATA = 12'h01c;
    // Reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Main control field positions
    localparam int POS_UNIT_ENABLE = 7;
    localparam int POS_LOAD_REQUEST = 6;
    localparam int POS_FALL_DB = 5;
    localparam int POS_RISE_DB = 4;
    // Modulation control field positions
    localparam int POS_MOD_ENABLE = 7;
    localparam int POS_MOD_POLARITY = 6;
    localparam int POS_MOD_SOFT = 5;
    // Writable masks; unimplemented bits read zero
    localparam logic [7:0] MASK_MAIN = 8'hff;
    localparam logic [7:0] MASK_MOD = 8'hef;
    localparam logic [7:0] MASK_SYNC = 8'h03;
    localparam logic [7:0] MASK_CLOCK = 8'h33;
    localparam logic [7:0] MASK_OE_FULL = 8'h3f;
    localparam logic [7:0] MASK_OE_PAIR = 8'h03;
    // Operating modes
    localparam logic [3:0] MODE_SINGLE = 4'h0;
    localparam logic [3:0] MODE_SKIP = 4'h6;
    localparam logic [3:0] MODE_SKIP_COMP = 4'h7;
    localparam logic [3:0] MODE_THREE_PHASE = 4'hc;
    // Modulation sources
    localparam logic [3:0] MSRC_SOFT = 4'h0;
    localparam logic [3:0] MSRC_CMP_LAST = 4'h3;
    localparam logic [3:0] MSRC_CAPCMP_ONE = 4'h5;
    localparam logic [3:0] MSRC_CAPCMP_TWO = 4'h6;
    localparam logic [3:0] MSRC_FEEDBACK = 4'h8;
    // Sync modes
    localparam logic [1:0] SYNC_NONE = 2'b00;
    localparam logic [1:0] SYNC_U1_FOLLOW = 2'b10;
    localparam logic [1:0] SYNC_U2_FOLLOW = 2'b01;
    // Clock sources
    localparam logic [1:0] CSRC_SYSTEM = 2'b00;
    localparam logic [1:0] CSRC_PLL = 2'b01;
    localparam logic [1:0] CSRC_PIN = 2'b10;
    // Last period count; a period spans 16 divided PWM clock ticks
    localparam logic [7:0] PERIOD_TICKS = 8'h0f;
    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage : smpwm_pkg

/* File: sim/smpwm_switch_stage.sv */
// Purpose: Behavioural power switch stage fed by the PWM output pins
// Assumes: Pins without PWM routing follow the port latch level
// Notes: The sense line carries a trip level commanded by the bench, one flop late
module smpwm_switch_stage
(
    input wire logic hclk,
    input wire logic [5:0] output_pin_enable,
    input wire logic unit_active,
    input wire logic [5:0] port_level,
    input wire logic trip_cmd,
    output logic [5:0] pin_level,
    output logic ext_feedback_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each pin takes the PWM level only where routing is on
    assign pin_level = (output_pin_enable & {6{unit_active}}) | (~output_pin_enable & port_level);
    // Sense comparator output is registered like a real level detector
    always_ff @(posedge hclk)
    begin
        ext_feedback_input <= trip_cmd;
    end
endmodule : smpwm_switch_stage

/* File: sim/tb_switch_mode_pwm_control_regs.sv */
// Purpose: Self-checking bench for two PWM control register units
// Assumes: Zero-wait AHB-Lite slaves; either unit follows the other's period on request
// Notes: Bus signals change by non-blocking assignment just after a rising edge
module tb_switch_mode_pwm_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import smpwm_pkg::*;
    logic hclk, hresetn, hwrite, hready, pll_tick, ext_clock_pin, cc1, cc2, trip_cmd, fb;
    logic [1:0] hsel, htrans, hro, hrs, pe, act, mg, fdb, rdb;
    logic [3:0] modes [2];
    logic [31:0] haddr, hwdata;
    logic [31:0] rdu [2];
    logic [31:0] ad [2];
    logic [5:0] oe [2];
    logic [5:0] pin_level;
    logic [2:0] hsize, comp;
    int n_errors, checked, cyc, cur, pdiv;
    assign hready = &hro;
    // Clock generator
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // PLL tick every third cycle, external pin clock with a four-cycle period
    always @(posedge hclk)
    begin
        pdiv <= (pdiv + 1) % 12;
        pll_tick <= (pdiv % 3 == 0);
        ext_clock_pin <= pdiv[1];
    end
    // Two units whose period events feed each other
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        smpwm_regs #(.UNIT_INDEX(u + 1)) i_smpwm_regs
        (
            .hclk(hclk), .hresetn(hresetn), .hsel(hsel[u]), .haddr(haddr), .htrans(htrans),
            .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
            .hreadyout(hro[u]), .hresp(hrs[u]), .hrdata(rdu[u]), .pll_tick(pll_tick),
            .ext_clock_pin(ext_clock_pin), .ext_feedback_input(fb), .comparator_out(comp),
            .capture_compare_unit_one(cc1), .capture_compare_unit_two(cc2),
            .master_period_event(pe[1 - u]), .period_event(pe[u]), .unit_active(act[u]),
            .modulation_gate(mg[u]), .fall_deadband_enable(fdb[u]),
            .rise_deadband_enable(rdb[u]), .mode_single(modes[u][3]),
            .mode_skip(modes[u][2]), .mode_skip_comp(modes[u][1]),
            .mode_three_phase(modes[u][0]), .output_pin_enable(oe[u]), .active_data(ad[u])
        );
    end
    smpwm_switch_stage i_smpwm_switch_stage
    (
        .hclk(hclk), .output_pin_enable(oe[0]), .unit_active(act[0]),
        .port_level(6'h2a), .trip_cmd(trip_cmd), .pin_level(pin_level),
        .ext_feedback_input(fb)
    );
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One single word transfer to the unit picked by cur
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 2'b01 << cur;
        haddr <= {20'h00000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 2'b00;
        htrans <= 2'b00;
        hwdata <= wd;
        // Data phase ends at the edge that samples hready high; read data is taken there
        do @(posedge hclk); while (hready !== 1'b1);
        rd = rdu[cur];
        chk("response", {31'h0, hrs[cur]}, 32'h0);
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        chk(what, v, exp);
    endtask : rchk
    // Counts negedges until a period event of unit u shows, at most 400
    task automatic wait_pe(input int u, output int n);
        n = 0;
        @(negedge hclk);
        while (pe[u] !== 1'b1 && n < 400)
        begin
            @(negedge hclk);
            n++;
        end
    endtask : wait_pe
    task automatic t_reset();
        for (int i = 0; i < 16; i++)
        begin
            cur = i / 8;
            rchk(12'(4 * (i % 8)), 32'h0, "reset value");
        end
        for (cur = 0; cur < 2; cur++)
            chk("idle outputs", 32'({hro[cur], mg[cur], modes[cur], act[cur], fdb[cur], rdb[cur], oe[cur]}), 32'h7000);
        cur = 0;
    endtask : t_reset
    task automatic t_masks();
        logic [11:0] ofs [5];
        logic [31:0] msk [5];
        for (cur = 0; cur < 2; cur++)
        begin
            ofs = '{OFS_MODULATION, cur ? OFS_UNIT2_SYNC : OFS_UNIT1_SYNC, OFS_CLOCK_SELECT,
                OFS_OUTPUT_ENABLE, OFS_BUFFER_DATA};
            msk = '{32'(MASK_MOD), 32'(MASK_SYNC), 32'(MASK_CLOCK),
                32'(cur ? MASK_OE_PAIR : MASK_OE_FULL), 32'hffff_ffff};
            for (int i = 0; i < 5; i++)
            begin
                wr(ofs[i], 32'hffff_ffff);
                rchk(ofs[i], msk[i], "writable bits");
            end
            chk("pin enables", 32'(oe[cur]), msk[3]);
            chk("active copy", ad[cur], 32'hffff_ffff);
            wr(OFS_ACTIVE_DATA, 32'h0);
            rchk(OFS_ACTIVE_DATA, 32'hffff_ffff, "read-only copy");
            wr(12'h100, 32'hffff_ffff);
            rchk(12'h100, 32'h0, "unmapped");
            for (int i = 0; i < 5; i++)
                wr(ofs[i], 32'h0);
        end
        cur = 0;
    endtask : t_masks
    task automatic t_modes();
        logic [3:0] code [5] = '{MODE_SINGLE, MODE_SKIP, MODE_SKIP_COMP, MODE_THREE_PHASE, 4'hd};
        for (int i = 0; i < 5; i++)
        begin
            wr(OFS_MAIN_CONTROL, {24'h0, 2'b00, 2'(i), code[i]});
            @(negedge hclk);
            chk("mode decode", 32'(modes[0]), i < 4 ? 32'h8 >> i : 32'h0);
            chk("dead band", 32'({fdb[0], rdb[0]}), 32'(i % 4));
        end
    endtask : t_modes
    // Entry: control value, {comparators, unit one, unit two, trip}, expected gate
    task automatic t_modulation();
        logic [14:0] tab [15] = '{{8'h00, 6'o00, 1'b1}, {8'h20, 6'o00, 1'b1},
            {8'h80, 6'o00, 1'b0}, {8'ha0, 6'o00, 1'b1}, {8'hc0, 6'o00, 1'b1},
            {8'he0, 6'o00, 1'b0}, {8'h81, 6'o10, 1'b1}, {8'ha1, 6'o00, 1'b0},
            {8'hc2, 6'o20, 1'b0}, {8'h83, 6'o40, 1'b1}, {8'h85, 6'o04, 1'b1},
            {8'h86, 6'o02, 1'b1}, {8'hc6, 6'o00, 1'b1}, {8'h88, 6'o01, 1'b1},
            {8'h88, 6'o00, 1'b0}};
        wr(OFS_MAIN_CONTROL, 32'h80);
        wr(OFS_OUTPUT_ENABLE, 32'h0f);
        foreach (tab[i])
        begin
            {comp, cc1, cc2, trip_cmd} <= tab[i][6:1];
            wr(OFS_MODULATION, {24'h0, tab[i][14:7]});
            repeat (5) @(posedge hclk);
            @(negedge hclk);
            chk("gate", {30'h0, act[0], mg[0]}, {30'h0, {2{tab[i][0]}}});
            chk("pins", 32'(pin_level), 32'({2'b10, {4{tab[i][0]}}}));
        end
        wr(OFS_MODULATION, 32'h0);
        wr(OFS_MAIN_CONTROL, 32'h0);
        @(negedge hclk);
        chk("disabled", {30'h0, act[0], mg[0]}, 32'h1);
    endtask : t_modulation
    task automatic t_period();
        logic [7:0] cs [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
        int gap [7] = '{16, 32, 64, 128, 48, 64, 401};
        int n;
        wr(OFS_MAIN_CONTROL, 32'h80);
        for (int i = 0; i < 7; i++)
        begin
            wr(OFS_CLOCK_SELECT, {24'h0, cs[i]});
            wait_pe(0, n);
            wait_pe(0, n);
            wait_pe(0, n);
            chk("period", 32'(n + 1), 32'(gap[i]));
        end
    endtask : t_period
    task automatic t_load();
        int n;
        wr(OFS_CLOCK_SELECT, 32'h0);
        wait_pe(0, n);
        wr(OFS_BUFFER_DATA, 32'h1234_5678);
        wr(OFS_MAIN_CONTROL, 32'hc0);
        rchk(OFS_MAIN_CONTROL, 32'hc0, "load pending");
        chk("copy held", ad[0], 32'h0);
        wait_pe(0, n);
        @(negedge hclk);
        chk("copy loaded", ad[0], 32'h1234_5678);
        rchk(OFS_MAIN_CONTROL, 32'h80, "load cleared");
    endtask : t_load
    // Slave on the PLL clock, master every 16 cycles; misses are master events alone
    task automatic t_sync();
        int miss, u;
        for (int k = 0; k < 6; k++)
        begin
            u = k / 3;
            if (k % 3 == 0)
            begin
                cur = u;
                wr(OFS_CLOCK_SELECT, 32'h01);
                cur = 1 - u;
                wr(OFS_MAIN_CONTROL, 32'h80);
                wr(OFS_CLOCK_SELECT, 32'h00);
            end
            cur = u;
            wr(u ? OFS_UNIT2_SYNC : OFS_UNIT1_SYNC, k % 3 == 0 ? 32'h0 : ((k % 3 == 1) ^ (k >= 3)) ? 32'h2 : 32'h1);
            miss = 0;
            repeat (200)
            begin
                @(negedge hclk);
                if (pe[1 - u] === 1'b1)
                    miss += 32'(pe[u] !== 1'b1);
            end
            chk("follows master", 32'(miss == 0), 32'(k % 3 == 1));
        end
    endtask : t_sync
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Hang guard
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    // Main sequence
    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, comp, cc1, cc2, trip_cmd} = '0;
        {cur, n_errors, checked} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_masks();
        t_modes();
        t_modulation();
        t_period();
        t_load();
        t_sync();
        end_of_test();
    end
endmodule : tb_switch_mode_pwm_control_regs
